// >>> cbt_bus_peer.sv
// Far-side bus transceiver model: drives the p legs of data and sync.
// Assumes the bench resolves each wire against the device's bus enable.
`timescale 1ns/10ps
module cbt_bus_peer (
	// Clock.
	input wire logic clk_in,
	// Levels driven on the p legs.
	output logic line_a_out,
	output logic line_b_out,
	output logic sync_out
);
	// Lines idle low until a transfer starts.
	initial begin
		line_a_out = 1'h0;
		line_b_out = 1'h0;
		sync_out = 1'h0;
	end
	// One bus clock transition; data is set a cycle ahead so it is stable when sampled.
	task automatic put(input logic a, input logic b);
		@(negedge clk_in);
		line_a_out = a;
		line_b_out = b;
		@(negedge clk_in);
		sync_out = ~sync_out;
	endtask
endmodule

// >>> cbt_edge_det.sv
// Edge detector for one synchronous input level.
// Assumes the input is already synchronous to clk_in.
`timescale 1ns/10ps
module cbt_edge_det
	import cbt_pkg::*;
(
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Level to watch.
	input wire logic level_in,
	// Edge pulses, one cycle each.
	output logic rise_out,
	output logic fall_out
);
	// Last seen level of the input.
	logic prev;

	// Keep the previous level so edges can be seen.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prev <= 1'h0;
		end else begin
			prev <= level_in;
		end
	end

	// Edges are combinational from the stored level.
	assign rise_out = level_in & ~prev;
	assign fall_out = ~level_in & prev;
endmodule

// >>> cbt_pkg.sv
// Shared constants and types for the CPU-side bus transceiver.
// Assumes a single 50 MHz system clock; all pins are sampled synchronously.
package cbt_pkg;
	// System clock period in nanoseconds.
	localparam int CBT_CLK_PERIOD_NS = 20;
	// Reset value of the two phase clocks.
	localparam logic CBT_PHASE_A_RESET = 1'h0;
	localparam logic CBT_PHASE_B_RESET = 1'h1;
	// Idle level of the serial data and clock lines.
	localparam logic CBT_LINE_IDLE = 1'h0;
	// Operating modes, one-hot coded.
	typedef enum logic [1:0] {
		CBT_MODE_RX = 2'h1,
		CBT_MODE_TX = 2'h2
	} cbt_mode_type;
endpackage

// >>> cbt_transceiver.sv
// CPU-side transceiver between a serial host port and a differential bus.
// Assumes all inputs are synchronous to clk_in and the master timebase is far slower.
`timescale 1ns/10ps
module cbt_transceiver
	import cbt_pkg::*;
(
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Mode, clear and master timebase.
	input wire logic dir_in,
	input wire logic clear_n_in,
	input wire logic master_timebase_in,
	output logic dir_n_out,
	// Phase clocks and forwarded timebase.
	output logic phase_a_out,
	output logic phase_b_out,
	output logic bus_timebase_pair_p_out,
	output logic bus_timebase_pair_n_out,
	// Host-side serial pins.
	input wire logic host_serial_line_a_in,
	output logic host_serial_line_a_out,
	input wire logic host_serial_line_b_in,
	output logic host_serial_line_b_out,
	input wire logic host_sync_clk_in,
	output logic host_sync_clk_out,
	output logic host_oe_out,
	// Bus-side differential pairs.
	input wire logic bus_line_a_pair_p_in,
	input wire logic bus_line_a_pair_n_in,
	output logic bus_line_a_pair_p_out,
	output logic bus_line_a_pair_n_out,
	input wire logic bus_line_b_pair_p_in,
	input wire logic bus_line_b_pair_n_in,
	output logic bus_line_b_pair_p_out,
	output logic bus_line_b_pair_n_out,
	input wire logic bus_sync_pair_p_in,
	input wire logic bus_sync_pair_n_in,
	output logic bus_sync_pair_p_out,
	output logic bus_sync_pair_n_out,
	output logic bus_oe_out
);
	// Whole state of the block.
	typedef struct packed {
		cbt_mode_type mode;
		logic dir_n;
		logic phase_a;
		logic phase_b;
		logic timebase;
		logic line_a;
		logic line_b;
		logic rx_strobe_enable_ff;
		logic reg_rst;
		logic tx_gate;
		logic sync_lvl;
		logic host_clk;
		logic host_oe;
		logic bus_oe;
		// Complement legs of the differential outputs, each held in its own flop.
		logic timebase_n;
		logic line_a_n;
		logic line_b_n;
		logic sync_n;
	} cbt_state_type;

	cbt_state_type st;
	cbt_state_type next_st;
	// Master timebase edges.
	logic mt_rise;
	logic mt_fall;
	// Received bus clock edges.
	logic bs_rise;
	logic bs_fall;
	logic bs_edge;
	// The n leg is unused in logic: the p leg alone carries the level here.
	logic rx_sync_lvl;

	assign rx_sync_lvl = bus_sync_pair_p_in;
	assign bs_edge = bs_rise | bs_fall;

	// Master timebase edge finder.
	cbt_edge_det u_mt_edge (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.level_in(master_timebase_in),
		.rise_out(mt_rise),
		.fall_out(mt_fall)
	);

	// Received bus clock edge finder.
	cbt_edge_det u_bs_edge (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.level_in(rx_sync_lvl),
		.rise_out(bs_rise),
		.fall_out(bs_fall)
	);

	// Next-state logic for the whole transceiver.
	always_comb begin
		next_st = st;
		next_st.dir_n = ~dir_in;
		next_st.timebase = master_timebase_in;
		// Phase clocks divide the master timebase by two.
		if (mt_rise) begin
			next_st.phase_a = ~st.phase_a;
			next_st.phase_b = st.phase_a;
		end
		// Mode selection; leaving transmit needs no clock edge.
		case (st.mode)
			CBT_MODE_RX: begin
				if (!dir_in && mt_rise) begin
					next_st.mode = CBT_MODE_TX;
				end
			end
			CBT_MODE_TX: begin
				if (dir_in) begin
					next_st.mode = CBT_MODE_RX;
				end
			end
			default: begin
				next_st.mode = CBT_MODE_RX;
			end
		endcase
		if (st.mode == CBT_MODE_RX) begin
			next_st.tx_gate = 1'h0;
			// Every bus clock transition samples data and flips the strobe flop.
			if (bs_edge) begin
				next_st.line_a = bus_line_a_pair_p_in;
				next_st.line_b = bus_line_b_pair_p_in;
				next_st.rx_strobe_enable_ff = ~st.rx_strobe_enable_ff;
			end else if (st.reg_rst && mt_rise) begin
				// The strobe stayed odd from a master fall to the next master rise, so it was spurious.
				next_st.rx_strobe_enable_ff = 1'h0;
			end
			// The arming flop is held clear while the strobe flop is clear.
			if (!st.rx_strobe_enable_ff) begin
				next_st.reg_rst = 1'h0;
			end else if (mt_fall) begin
				next_st.reg_rst = 1'h1;
			end
			if (bs_edge || (st.reg_rst && mt_rise)) begin
				next_st.reg_rst = 1'h0;
			end
		end else begin
			next_st.rx_strobe_enable_ff = 1'h0;
			next_st.reg_rst = 1'h0;
			// Data taken on master rises; the gate opens while host clock is low.
			if (mt_rise) begin
				next_st.line_a = host_serial_line_a_in;
				next_st.line_b = host_serial_line_b_in;
				next_st.tx_gate = ~host_sync_clk_in;
			end
			// Bus clock moves on both master edges, mid bit for the far end.
			if (st.tx_gate && (mt_rise || mt_fall)) begin
				next_st.sync_lvl = ~st.sync_lvl;
			end
		end
		// Clear wipes every flop of the transfer path.
		if (!clear_n_in) begin
			next_st.line_a = CBT_LINE_IDLE;
			next_st.line_b = CBT_LINE_IDLE;
			next_st.rx_strobe_enable_ff = 1'h0;
			next_st.reg_rst = 1'h0;
			next_st.tx_gate = 1'h0;
			next_st.sync_lvl = CBT_LINE_IDLE;
			next_st.phase_a = CBT_PHASE_A_RESET;
			next_st.phase_b = CBT_PHASE_B_RESET;
			next_st.mode = dir_in ? CBT_MODE_RX : st.mode;
		end
		// Host clock is the inverted strobe flop; clear in receive holds it low.
		next_st.host_clk = ~next_st.rx_strobe_enable_ff;
		if (!clear_n_in) begin
			next_st.host_clk = 1'h0;
		end
		// Complement legs get flops of their own so no output passes through a gate.
		next_st.timebase_n = ~next_st.timebase;
		next_st.line_a_n = ~next_st.line_a;
		next_st.line_b_n = ~next_st.line_b;
		next_st.sync_n = ~next_st.sync_lvl;
		next_st.host_oe = (next_st.mode == CBT_MODE_RX) && dir_in;
		next_st.bus_oe = (next_st.mode == CBT_MODE_TX);
	end

	// Single state register.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st <= '{mode: CBT_MODE_RX, dir_n: 1'h0, phase_a: CBT_PHASE_A_RESET,
				phase_b: CBT_PHASE_B_RESET, host_clk: 1'h1, timebase_n: 1'h1, line_a_n: 1'h1,
				line_b_n: 1'h1, sync_n: 1'h1, default: 1'h0};
		end else begin
			st <= next_st;
		end
	end

	// All outputs come straight from the state flops.
	assign dir_n_out = st.dir_n;
	assign phase_a_out = st.phase_a;
	assign phase_b_out = st.phase_b;
	assign bus_timebase_pair_p_out = st.timebase;
	assign bus_timebase_pair_n_out = st.timebase_n;
	assign host_serial_line_a_out = st.line_a;
	assign host_serial_line_b_out = st.line_b;
	assign host_sync_clk_out = st.host_clk;
	assign host_oe_out = st.host_oe;
	assign bus_line_a_pair_p_out = st.line_a;
	assign bus_line_a_pair_n_out = st.line_a_n;
	assign bus_line_b_pair_p_out = st.line_b;
	assign bus_line_b_pair_n_out = st.line_b_n;
	assign bus_sync_pair_p_out = st.sync_lvl;
	assign bus_sync_pair_n_out = st.sync_n;
	assign bus_oe_out = st.bus_oe;

	// Checks on the behaviour above.
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	dir_inverse_a: assert property (##1 dir_n_out == !$past(dir_in))
		else $error("direction inverse wrong");
	phase_pair_a: assert property (phase_a_out != phase_b_out)
		else $error("phase clocks not complementary");
	phase_step_a: assert property (mt_rise && clear_n_in |=> phase_a_out != $past(phase_a_out))
		else $error("phase clock did not toggle");
	timebase_fwd_a: assert property (##1 bus_timebase_pair_p_out == $past(master_timebase_in)
		&& bus_timebase_pair_n_out != bus_timebase_pair_p_out)
		else $error("timebase not forwarded");
	rx_sample_a: assert property (st.mode == CBT_MODE_RX && bs_edge && clear_n_in
		|=> host_serial_line_a_out == $past(bus_line_a_pair_p_in))
		else $error("receive data not sampled");
	tx_data_a: assert property (st.mode == CBT_MODE_TX && mt_rise && clear_n_in
		|=> bus_line_b_pair_p_out == $past(host_serial_line_b_in))
		else $error("transmit data not registered");
	clear_rx_a: assert property (!clear_n_in && dir_in
		|=> host_sync_clk_out == 1'h0 && host_oe_out)
		else $error("clear did not pull host clock low");
	tx_enter_a: assert property (st.mode == CBT_MODE_RX && !dir_in && mt_rise && clear_n_in
		|=> bus_oe_out ##0 !host_oe_out)
		else $error("transmit not entered");
	spur_clear_a: assert property (st.mode == CBT_MODE_RX && st.reg_rst && mt_rise && !bs_edge
		&& clear_n_in |=> host_sync_clk_out)
		else $error("spurious strobe not cleared");
	drive_excl_a: assert property (!(host_oe_out && bus_oe_out))
		else $error("both sides driven");
endmodule

// >>> tb_cbt_transceiver.sv
// Self-checking bench for the transceiver with a far-side bus model.
// Assumes the master timebase is slow: it toggles every four clocks.
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
	$display("BAD %s exp %h got %h", n, e, g); end end
module tb_cbt_transceiver;
	import cbt_pkg::*;
	logic clk_in = 1'h0, rst_n_in = 1'h0, dir_in = 1'h1, clear_n_in = 1'h1, mt = 1'h0;
	logic ha = 1'h0, hb = 1'h0, hc = 1'h1, pa, pb, ps, s0, ph;
	logic dir_n, pha, phb, tbp, tbn, hao, hbo, hco, hoe, ap, an, bp, bn, sp, sn, boe;
	logic wa, wb, wc, ba, bb, bs;
	int error_cnt = 0, samples_checked = 0;
	// Shared wires: whoever has its enable up sets the level.
	assign wa = hoe ? hao : ha;
	assign wb = hoe ? hbo : hb;
	assign wc = hoe ? hco : hc;
	assign ba = boe ? ap : pa;
	assign bb = boe ? bp : pb;
	assign bs = boe ? sp : ps;
	initial forever #10 clk_in = ~clk_in;
	// Master timebase runs free, changing off the sampling edge.
	initial forever begin
		repeat (4) @(negedge clk_in);
		mt = ~mt;
	end
	cbt_bus_peer u_cbt_bus_peer (.clk_in(clk_in), .line_a_out(pa), .line_b_out(pb),
		.sync_out(ps));
	cbt_transceiver u_cbt_transceiver (.clk_in(clk_in), .rst_n_in(rst_n_in), .dir_in(dir_in),
		.clear_n_in(clear_n_in), .master_timebase_in(mt), .dir_n_out(dir_n),
		.phase_a_out(pha), .phase_b_out(phb), .bus_timebase_pair_p_out(tbp),
		.bus_timebase_pair_n_out(tbn), .host_serial_line_a_in(wa),
		.host_serial_line_a_out(hao), .host_serial_line_b_in(wb),
		.host_serial_line_b_out(hbo), .host_sync_clk_in(wc), .host_sync_clk_out(hco),
		.host_oe_out(hoe), .bus_line_a_pair_p_in(ba), .bus_line_a_pair_n_in(~ba),
		.bus_line_a_pair_p_out(ap), .bus_line_a_pair_n_out(an), .bus_line_b_pair_p_in(bb),
		.bus_line_b_pair_n_in(~bb), .bus_line_b_pair_p_out(bp), .bus_line_b_pair_n_out(bn),
		.bus_sync_pair_p_in(bs), .bus_sync_pair_n_in(~bs), .bus_sync_pair_p_out(sp),
		.bus_sync_pair_n_out(sn), .bus_oe_out(boe));
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	// Phase clocks halve the master rate; the timebase pair follows the master.
	task automatic t_clocks();
		@(posedge mt);
		wait_n(3);
		ph = pha;
		`CHK("phase_b", ~ph, phb)
		`CHK("tb_p", 1'h1, tbp)
		`CHK("tb_n", 1'h0, tbn)
		@(negedge mt);
		wait_n(3);
		`CHK("tb_p", 1'h0, tbp)
		@(posedge mt);
		wait_n(3);
		`CHK("phase_a", ~ph, pha)
		$display("clocks done");
	endtask
	// Receive n host pulses: each is two bus transitions carrying two bit pairs.
	task automatic t_rx(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge mt);
			u_cbt_bus_peer.put(i[0], ~i[0]);
			wait_n(2);
			`CHK("rx_a", i[0], hao)
			`CHK("rx_b", ~i[0], hbo)
			`CHK("rx_clk", 1'h0, hco)
			`CHK("host_oe", 1'h1, hoe)
			u_cbt_bus_peer.put(~i[0], i[0]);
			wait_n(2);
			`CHK("rx_a2", ~i[0], hao)
			`CHK("rx_clk2", 1'h1, hco)
		end
		$display("rx %0d pulses done", n);
	endtask
	// Lone bus transitions, from each level, must not hold the host clock low for long.
	// Two of them leave the peer's sync low again, the level the device leaves after
	// transmit, so the bus handover back to receive shows no false transition.
	task automatic t_spurious();
		for (int k = 0; k < 2; k++) begin
			u_cbt_bus_peer.put(1'h0, 1'h0);
			wait_n(2);
			`CHK("lone_low", 1'h0, hco)
			wait_n(20);
			`CHK("lone_clr", 1'h1, hco)
		end
		$display("spurious done");
	endtask
	// Transmit: host pulse low across a master rise sends data and a gated clock.
	task automatic t_tx();
		dir_in = 1'h0;
		@(posedge mt);
		wait_n(3);
		`CHK("bus_oe", 1'h1, boe)
		`CHK("host_oe", 1'h0, hoe)
		`CHK("dir_n", 1'h1, dir_n)
		ha = 1'h1;
		hb = 1'h0;
		hc = 1'h0;
		@(posedge mt);
		wait_n(3);
		`CHK("tx_a_p", 1'h1, ap)
		`CHK("tx_a_n", 1'h0, an)
		`CHK("tx_b_p", 1'h0, bp)
		`CHK("tx_b_n", 1'h1, bn)
		s0 = sp;
		wait_n(4);
		`CHK("tx_sync", ~s0, sp)
		`CHK("tx_sync_n", s0, sn)
		hc = 1'h1;
		wait_n(8);
		`CHK("tx_sync_stop", s0, sp)
		dir_in = 1'h1;
		wait_n(2);
		`CHK("rx_back", 1'h0, boe)
		`CHK("rx_idle", 1'h1, hco)
		`CHK("dir_n2", 1'h0, dir_n)
		$display("tx done");
	endtask
	// Clear in receive mode pulls the host clock low and resets the phases.
	task automatic t_clear();
		clear_n_in = 1'h0;
		wait_n(2);
		`CHK("clr_clk", 1'h0, hco)
		`CHK("clr_pa", CBT_PHASE_A_RESET, pha)
		`CHK("clr_pb", CBT_PHASE_B_RESET, phb)
		clear_n_in = 1'h1;
		wait_n(2);
		`CHK("clr_end", 1'h1, hco)
		$display("clear done");
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Watchdog: the tests need well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge clk_in);
		error_cnt++;
		conclude();
	end
	initial begin
		wait_n(10);
		`CHK("rst_pa", 1'h0, pha)
		`CHK("rst_clk", 1'h1, hco)
		`CHK("rst_boe", 1'h0, boe)
		wait_n(2);
		rst_n_in = 1'h1;
		t_clocks();
		t_rx(1);
		t_rx(5);
		t_spurious();
		t_tx();
		t_clear();
		conclude();
	end
endmodule
